// ===== verilog/apl_ports.sv
// four analog ports: adc input, manometer pressure, process levels, dac output, logging
`timescale 1ns/1ps
module apl_ports #(
   parameter int UPDATE_CYCLES = apl_pkg::UPDATE_CYCLES,
   parameter int NCH           = apl_pkg::NCHAN
) (
   input  wire logic                                               clk,            // 40 MHz clock
   input  wire logic                                               resetn,         // async reset, low
   input  wire logic                                               panel_mode_we,  // panel writes modes
   input  wire logic [apl_pkg::NPORT-1:0]                          panel_mode,     // 1 = output
   input  wire logic                                               remote_mode_we, // remote writes modes
   input  wire logic [apl_pkg::NPORT-1:0]                          remote_mode,    // 1 = output
   input  wire logic [apl_pkg::NPORT-1:0]                          fmt_pressure,   // show as pressure
   input  wire logic [apl_pkg::NPORT-1:0]                          pmax_we,        // full-scale write
   input  wire logic [apl_pkg::PMAX_W-1:0]                         pmax_val,       // full-scale value
   input  wire logic [apl_pkg::NPORT-1:0][apl_pkg::ADC_W-1:0]      adc_code,       // converter pins
   output logic      [apl_pkg::NPORT-1:0][apl_pkg::ADC_W-1:0]      reading,        // input voltage code
   output logic      [apl_pkg::NPORT-1:0]                          overload,       // out of range
   output logic      [apl_pkg::NPORT-1:0][apl_pkg::PRESS_W-1:0]    pressure,       // manometer pressure
   output logic      [apl_pkg::NPORT-1:0]                          pressure_valid, // pressure usable
   input  wire logic                                               log_enable,     // data logging on
   input  wire logic [apl_pkg::LOG_AW-1:0]                         log_rd_addr,    // log read address
   output logic      [apl_pkg::LOG_W-1:0]                          log_rd_data,    // log read data
   output logic      [apl_pkg::LOG_AW-1:0]                         log_wr_ptr,     // next log slot
   input  wire logic [NCH-1:0][apl_pkg::PORT_IW-1:0]               chan_port,      // linked port
   input  wire logic [NCH-1:0][apl_pkg::ADC_W-1:0]                 chan_level,     // trip level
   input  wire logic [NCH-1:0]                                     chan_above,     // 1 = above
   output logic      [NCH-1:0]                                     chan_active,    // channel active
   input  wire logic [apl_pkg::NPORT-1:0][1:0]                     dac_src,        // output source
   input  wire logic [apl_pkg::NPORT-1:0][1:0]                     dac_gauge,      // gauge followed
   input  wire logic [apl_pkg::NPORT-1:0][apl_pkg::DAC_W-1:0]      manual_code,    // manual level
   input  wire logic [apl_pkg::NPORT-1:0][apl_pkg::DAC_W-1:0]      remote_code,    // remote level
   input  wire logic [apl_pkg::NPORT-1:0][apl_pkg::LOGP_W-1:0]     gauge_logp,     // log10 torr q8
   input  wire logic [apl_pkg::NPORT-1:0]                          gauge_off,      // gauge off
   input  wire logic [apl_pkg::NPORT-1:0]                          gauge_fault,    // gauge fault
   output logic      [apl_pkg::NPORT-1:0][apl_pkg::DAC_W-1:0]      dac_code,       // converter level
   output logic      [apl_pkg::NPORT-1:0]                          port_is_output, // 1 = output
   output logic                                                    update_tick     // refresh pulse
);
   import apl_pkg::*;

   localparam int CNT_W = $clog2(UPDATE_CYCLES + 1);

   typedef struct packed {
      logic [NPORT-1:0][ADC_W-1:0]   adc_meta;
      logic [NPORT-1:0][ADC_W-1:0]   adc_sync;
      logic [NPORT-1:0]              mode;
      logic [NPORT-1:0][PMAX_W-1:0]  pmax;
      logic [NPORT-1:0]              pmax_ok;
      logic [NPORT-1:0][ADC_W-1:0]   rdg;
      logic [NPORT-1:0]              ovl;
      logic [NPORT-1:0][PRESS_W-1:0] press;
      logic [NPORT-1:0]              press_ok;
      logic [NCH-1:0]                chan_act;
      logic [NPORT-1:0][DAC_W-1:0]   dac;
      logic [CNT_W-1:0]              cnt;
      logic                          tick;
      apl_lstate_t                   lstate;
      logic [PORT_IW-1:0]            lidx;
      logic [LOG_AW-1:0]             lptr;
   } apl_state_t;

   apl_state_t         st;
   apl_state_t         nx;
   logic [1:0]         rst_pipe;
   logic               rst_n;
   logic               wrap;
   logic               log_we;
   logic [LOG_W-1:0]   log_wdata;

   function automatic logic is_sat(input logic [ADC_W-1:0] code);
      return (code == ADC_POS_SAT) || (code == ADC_NEG_SAT);
   endfunction

   // linear scaling, negative voltages read as zero pressure
   function automatic logic [PRESS_W-1:0] to_press(input logic [ADC_W-1:0]  code,
                                                    input logic [PMAX_W-1:0] pm);
      logic [PROD_W-1:0] prod;
      prod = PROD_W'(code[ADC_W-2:0]) * PROD_W'(pm) * PROD_W'(PRESS_SCALE);
      if (code[ADC_W-1]) begin
         return '0;
      end
      if (|prod[PROD_W-1:PRESS_SHIFT+PRESS_W]) begin
         return '1;
      end
      return prod[PRESS_SHIFT+PRESS_W-1:PRESS_SHIFT];
   endfunction

   function automatic logic [DAC_W-1:0] gauge_to_dac(input logic signed [LOGP_W-1:0] lp,
                                                      input logic                     thermal);
      logic signed [LOGP_W-1:0] lo;
      logic signed [LOGP_W-1:0] hi;
      logic signed [LOGP_W-1:0] c;
      logic signed [LOGP_W:0]   vq;
      logic [19:0]              prod;
      lo = thermal ? THERM_LOGP_MIN : ION_LOGP_MIN;
      hi = thermal ? THERM_LOGP_MAX : ION_LOGP_MAX;
      c = (lp < lo) ? lo : ((lp > hi) ? hi : lp);
      vq = LOGP_W'(c) + (thermal ? THERM_V_OFS : ION_V_OFS);
      prod = 20'(vq[11:0]) * 20'(DAC_GAIN);
      return DAC_ZERO + DAC_W'(prod >> DAC_GAIN_SHIFT);
   endfunction

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   always_comb begin
      logic [ADC_W-1:0] v;
      logic [1:0]       g;
      nx = st;
      v = '0;
      g = '0;
      log_we = 1'b0;
      log_wdata = '0;
      // pins cross in through two stages; only the second is read
      nx.adc_meta = adc_code;
      nx.adc_sync = st.adc_meta;
      wrap = (st.cnt == CNT_W'(UPDATE_CYCLES - 1));
      nx.cnt = wrap ? '0 : st.cnt + 1'b1;
      nx.tick = wrap;
      if (panel_mode_we) begin
         nx.mode = panel_mode;
      end
      if (remote_mode_we) begin
         nx.mode = remote_mode;
      end
      for (int i = 0; i < NPORT; i++) begin
         if (pmax_we[i]) begin
            nx.pmax[i] = pmax_val;
            nx.pmax_ok[i] = (pmax_val != '0);
         end
      end
      if (wrap) begin
         for (int i = 0; i < NPORT; i++) begin
            if (!st.mode[i]) begin
               nx.rdg[i] = st.adc_sync[i];
               nx.ovl[i] = is_sat(st.adc_sync[i]);
               nx.press[i] = to_press(st.adc_sync[i], st.pmax[i]);
               nx.press_ok[i] = fmt_pressure[i] && st.pmax_ok[i] && !nx.ovl[i];
            end else begin
               nx.ovl[i] = 1'b0;
               nx.press_ok[i] = 1'b0;
               g = dac_gauge[i];
               unique case (dac_src[i])
                  SRC_MANUAL: nx.dac[i] = manual_code[i];
                  SRC_REMOTE: nx.dac[i] = remote_code[i];
                  SRC_GAUGE: begin
                     if (gauge_off[g]) begin
                        nx.dac[i] = DAC_ZERO;
                     end else if (gauge_fault[g]) begin
                        nx.dac[i] = DAC_FULL;
                     end else begin
                        nx.dac[i] = gauge_to_dac(gauge_logp[g], g[1]);
                     end
                  end
                  default: nx.dac[i] = st.dac[i];
               endcase
            end
         end
         for (int c = 0; c < NCH; c++) begin
            v = nx.rdg[chan_port[c]];
            // an overloaded or output port never trips a channel
            nx.chan_act[c] = !st.mode[chan_port[c]] && !nx.ovl[chan_port[c]] &&
                             (chan_above[c] ? ($signed(v) > $signed(chan_level[c]))
                                            : ($signed(v) < $signed(chan_level[c])));
         end
      end
      unique case (st.lstate)
         LS_IDLE: begin
            if (wrap && log_enable) begin
               nx.lstate = LS_WRITE;
               nx.lidx = '0;
            end
         end
         LS_WRITE: begin
            if (!st.mode[st.lidx]) begin
               log_we = 1'b1;
               log_wdata = {st.lidx, st.ovl[st.lidx], st.rdg[st.lidx]};
               nx.lptr = st.lptr + 1'b1;
            end
            nx.lidx = st.lidx + 1'b1;
            if (st.lidx == PORT_IW'(NPORT - 1)) begin
               nx.lstate = LS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.dac <= {NPORT{DAC_ZERO}};
      end else begin
         st <= nx;
      end
   end

   apl_log_mem #(
      .W  (LOG_W),
      .AW (LOG_AW)
   ) u_log_mem (
      .clk   (clk),
      .rst_n (rst_n),
      .we    (log_we),
      .waddr (st.lptr),
      .wdata (log_wdata),
      .raddr (log_rd_addr),
      .rdata (log_rd_data)
   );

   assign reading        = st.rdg;
   assign overload       = st.ovl;
   assign pressure       = st.press;
   assign pressure_valid = st.press_ok;
   assign chan_active    = st.chan_act;
   assign dac_code       = st.dac;
   assign port_is_output = st.mode;
   assign update_tick    = st.tick;
   assign log_wr_ptr     = st.lptr;

   a_mode_remote: assert property (@(posedge clk) disable iff (!rst_n)
      remote_mode_we |=> port_is_output == $past(remote_mode))
      else $error("remote mode write not applied");
   a_ovl_flag: assert property (@(posedge clk) disable iff (!rst_n)
      (wrap && !st.mode[0] && is_sat(st.adc_sync[0])) |=> overload[0] && update_tick)
      else $error("overload not flagged");
   a_log_burst: assert property (@(posedge clk) disable iff (!rst_n)
      (wrap && log_enable && st.lstate == LS_IDLE) |=> (st.lstate == LS_WRITE)[*4] ##1 st.lstate == LS_IDLE)
      else $error("log burst length wrong");
   a_chan_output: assert property (@(posedge clk) disable iff (!rst_n)
      (wrap && st.mode[chan_port[0]]) |=> !chan_active[0])
      else $error("channel active on output port");
   a_manual_src: assert property (@(posedge clk) disable iff (!rst_n)
      (wrap && st.mode[0] && dac_src[0] == SRC_MANUAL) |=> dac_code[0] == $past(manual_code[0]))
      else $error("manual level not driven");
   a_gauge_off: assert property (@(posedge clk) disable iff (!rst_n)
      (wrap && st.mode[1] && dac_src[1] == SRC_GAUGE && gauge_off[dac_gauge[1]]) |=> dac_code[1] == DAC_ZERO)
      else $error("gauge off code wrong");
   a_gauge_fault: assert property (@(posedge clk) disable iff (!rst_n)
      (wrap && st.mode[1] && dac_src[1] == SRC_GAUGE && !gauge_off[dac_gauge[1]] && gauge_fault[dac_gauge[1]])
      |=> dac_code[1] == DAC_FULL)
      else $error("gauge fault code wrong");
   a_press_pmax: assert property (@(posedge clk) disable iff (!rst_n)
      (wrap && !st.pmax_ok[2]) |=> !pressure_valid[2])
      else $error("pressure valid without full scale");
   a_dac_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !wrap |=> $stable(dac_code) && !update_tick)
      else $error("output changed between refreshes");
   a_clamp_range: assert property (@(posedge clk) disable iff (!rst_n)
      (wrap && st.mode[3] && dac_src[3] == SRC_GAUGE && !gauge_off[dac_gauge[3]] && !gauge_fault[dac_gauge[3]])
      |=> dac_code[3] inside {[DAC_PRESS_MIN:DAC_PRESS_MAX]})
      else $error("gauge level outside mapping range");
endmodule

// ===== pkg/apl_pkg.sv
// constants and types shared by the analog port controller
package apl_pkg;
   localparam int NPORT          = 4;
   localparam int PORT_IW        = 2;
   localparam int ADC_W          = 14;
   localparam int DAC_W          = 12;
   localparam int PMAX_W         = 16;
   localparam int PRESS_W        = 16;
   localparam int LOGP_W         = 13;          // signed log10(Torr), 8 fraction bits
   localparam int LOGP_FRAC      = 8;
   localparam int NCHAN          = 4;

   // refresh timing
   localparam int CLK_HZ         = 40_000_000;
   localparam int UPDATE_HZ      = 2;
   localparam int UPDATE_CYCLES  = CLK_HZ / UPDATE_HZ;

   // adc: two's complement over -12 V .. +12 V, rails mean out of range
   localparam logic [ADC_W-1:0] ADC_POS_SAT = 14'h1FFF;
   localparam logic [ADC_W-1:0] ADC_NEG_SAT = 14'h2000;

   // manometer: 10 V = code 6827, pressure = code * pmax * 2457 / 2^24
   localparam int PROD_W         = 41;
   localparam int PRESS_SCALE    = 2457;
   localparam int PRESS_SHIFT    = 24;

   // dac: offset binary over -12 V .. +12 V
   localparam logic [DAC_W-1:0] DAC_ZERO      = 12'h800;
   localparam logic [DAC_W-1:0] DAC_FULL      = 12'hFFF;
   localparam logic [DAC_W-1:0] DAC_PRESS_MIN = 12'h8AB;
   localparam logic [DAC_W-1:0] DAC_PRESS_MAX = 12'hF59;
   localparam int DAC_GAIN       = 171;         // 4096/24 codes per volt, in q8
   localparam int DAC_GAIN_SHIFT = 8;

   // log-pressure limits and volt offsets, q8
   localparam logic signed [LOGP_W-1:0] ION_LOGP_MIN   = -13'sh0B00;
   localparam logic signed [LOGP_W-1:0] ION_LOGP_MAX   = -13'sh0100;
   localparam logic signed [LOGP_W-1:0] THERM_LOGP_MIN = -13'sh0400;
   localparam logic signed [LOGP_W-1:0] THERM_LOGP_MAX = 13'sh0400;
   localparam logic signed [LOGP_W:0]   ION_V_OFS      = 14'sh0C00;
   localparam logic signed [LOGP_W:0]   THERM_V_OFS    = 14'sh0500;

   // log memory
   localparam int LOG_AW         = 8;
   localparam int LOG_W          = PORT_IW + 1 + ADC_W;

   typedef enum logic [1:0] {
      SRC_MANUAL = 2'b00,
      SRC_REMOTE = 2'b01,
      SRC_GAUGE  = 2'b11
   } apl_src_t;

   // gauge select: bit 1 set means a thermal-conductivity gauge
   localparam logic [1:0] G_FIRST_ION   = 2'h0;
   localparam logic [1:0] G_SECOND_ION  = 2'h1;
   localparam logic [1:0] G_FIRST_TH    = 2'h2;
   localparam logic [1:0] G_SECOND_TH   = 2'h3;

   typedef enum logic {
      LS_IDLE  = 1'b0,
      LS_WRITE = 1'b1
   } apl_lstate_t;
endpackage

// ===== verilog/apl_log_mem.sv
// log memory: one write port, registered read port
`timescale 1ns/1ps
module apl_log_mem #(
   parameter int W  = 17,
   parameter int AW = 8
) (
   input  wire logic          clk,    // system clock
   input  wire logic          rst_n,  // synchronised reset
   input  wire logic          we,     // write strobe
   input  wire logic [AW-1:0] waddr,  // write address
   input  wire logic [W-1:0]  wdata,  // write data
   input  wire logic [AW-1:0] raddr,  // read address
   output logic      [W-1:0]  rdata   // read data, one cycle late
);
   logic [W-1:0] mem [2**AW];

   // array has no reset so it can map onto block ram
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= '0;
      end else begin
         rdata <= mem[raddr];
      end
   end
endmodule

// ===== tb/apl_equip.sv
// behavioural analog equipment and pressure gauges beyond the four ports
`timescale 1ns/1ps
module apl_equip (
   input  wire logic                                          clk,            // system clock
   input  wire logic [apl_pkg::NPORT-1:0]                     port_is_output, // port driven by device
   input  wire logic [apl_pkg::NPORT-1:0][apl_pkg::DAC_W-1:0] dac_code,       // device output level
   output logic      [apl_pkg::NPORT-1:0][apl_pkg::ADC_W-1:0] adc_code,       // converter pins
   output logic      [apl_pkg::NPORT-1:0][apl_pkg::LOGP_W-1:0] gauge_logp,    // gauge log pressure
   output logic      [apl_pkg::NPORT-1:0]                     gauge_off,      // gauge off
   output logic      [apl_pkg::NPORT-1:0]                     gauge_fault     // gauge fault
);
   import apl_pkg::*;
   logic [ADC_W-1:0] src [NPORT];

   initial begin
      src = '{default: '0};
      gauge_logp = '0;
      gauge_off = '0;
      gauge_fault = '0;
   end

   // a driven port reads back its own level, rescaled to the wider converter
   always @(negedge clk) begin
      for (int p = 0; p < NPORT; p++) begin
         adc_code[p] <= port_is_output[p] ? {~dac_code[p][11], dac_code[p][10:0], 2'b00} : src[p];
      end
   end

   task automatic set_input(input int p, input logic [ADC_W-1:0] v);
      src[p] = v;
   endtask

   task automatic set_gauge(input int g, input logic [LOGP_W-1:0] lp, input logic off, input logic flt);
      gauge_logp[g] = lp;
      gauge_off[g] = off;
      gauge_fault[g] = flt;
   endtask
endmodule

// ===== tb/apl_ports_tb_top.sv
// self-checking bench for the analog port controller
`timescale 1ns/1ps
module apl_ports_tb_top;
   import apl_pkg::*;
   localparam int UPD = 32;
   logic                           clk, resetn, panel_mode_we, remote_mode_we, log_enable, update_tick;
   logic [NPORT-1:0]               panel_mode, remote_mode, fmt_pressure, pmax_we, overload, pressure_valid;
   logic [NPORT-1:0]               gauge_off, gauge_fault, port_is_output;
   logic [PMAX_W-1:0]              pmax_val;
   logic [NPORT-1:0][ADC_W-1:0]    adc_code, reading;
   logic [NPORT-1:0][PRESS_W-1:0]  pressure;
   logic [LOG_AW-1:0]              log_rd_addr, log_wr_ptr;
   logic [LOG_W-1:0]               log_rd_data;
   logic [NCHAN-1:0][PORT_IW-1:0]  chan_port;
   logic [NCHAN-1:0][ADC_W-1:0]    chan_level;
   logic [NCHAN-1:0]               chan_above, chan_active;
   logic [NPORT-1:0][1:0]          dac_src, dac_gauge;
   logic [NPORT-1:0][DAC_W-1:0]    manual_code, remote_code, dac_code;
   logic [NPORT-1:0][LOGP_W-1:0]   gauge_logp;
   int                             failures, comparisons, e_ptr;
   int                             code [4], e_out [4], e_dac [4], e_pmax [4], e_ovl [4];
   int                             qa [$], qd [$];

   apl_ports #(.UPDATE_CYCLES(UPD), .NCH(NCHAN)) i_dut (.clk, .resetn, .panel_mode_we, .panel_mode,
      .remote_mode_we, .remote_mode, .fmt_pressure, .pmax_we, .pmax_val, .adc_code, .reading, .overload,
      .pressure, .pressure_valid, .log_enable, .log_rd_addr, .log_rd_data, .log_wr_ptr, .chan_port,
      .chan_level, .chan_above, .chan_active, .dac_src, .dac_gauge, .manual_code, .remote_code,
      .gauge_logp, .gauge_off, .gauge_fault, .dac_code, .port_is_output, .update_tick);
   apl_equip i_equip (.clk, .port_is_output, .dac_code, .adc_code, .gauge_logp, .gauge_off, .gauge_fault);

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic wait_tick();
      int n;
      n = 0;
      @(negedge clk);
      while (update_tick !== 1'b1 && n < 3 * UPD) begin
         @(negedge clk);
         n++;
      end
      check("update_tick", update_tick, 1'b1);
   endtask

   function automatic int sx(int v, int w);
      return (v >= (1 << (w - 1))) ? v - (1 << w) : v;
   endfunction

   // off outranks fault, pressure clamped so it never aliases either code
   function automatic int gauge_dac(int g, int lp, bit off, bit flt);
      int lo, hi;
      if (off) return 'h800;
      if (flt) return 'hFFF;
      lo = g[1] ? -'h400 : -'hB00;
      hi = g[1] ? 'h400 : -'h100;
      lp = (lp < lo) ? lo : ((lp > hi) ? hi : lp);
      return 'h800 + (((lp + (g[1] ? 'h500 : 'hC00)) * 171) >>> 8);
   endfunction

   initial begin
      repeat (60 * UPD) @(posedge clk);
      failures++;
      end_of_test();
   end

   initial begin
      int ov, pv, cp, g;
      longint pr;
      void'($urandom(44024));
      {resetn, panel_mode_we, remote_mode_we, log_enable, panel_mode, remote_mode, fmt_pressure} = '0;
      {pmax_we, pmax_val, log_rd_addr, chan_port, chan_level, chan_above, dac_src, dac_gauge} = '0;
      {manual_code, remote_code} = '0;
      e_pmax = '{default: 0};
      e_dac = '{default: 'h800};
      e_ptr = 0;
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      @(negedge clk);
      for (int p = 0; p < NPORT; p++) check("dac_code at reset", dac_code[p], 'h800);
      wait_tick();
      repeat (UPD - 1) @(negedge clk);
      check("tick gap", update_tick, 1'b0);
      @(negedge clk);
      check("tick period", update_tick, 1'b1);
      for (int r = 0; r < 8; r++) begin
         @(negedge clk);
         panel_mode = 4'($urandom);
         remote_mode = 4'($urandom);
         panel_mode_we = 1'b1;
         remote_mode_we = r[0];
         @(negedge clk);
         {panel_mode_we, remote_mode_we} = '0;
         for (int p = 0; p < NPORT; p++) begin
            e_out[p] = r[0] ? remote_mode[p] : panel_mode[p];
            check("port_is_output", port_is_output[p], e_out[p][0]);
         end
         for (int p = 0; p < NPORT; p++) begin
            e_pmax[p] = (p == r % 4) ? 0 : $urandom_range(1, 65535);
            pmax_val = e_pmax[p][15:0];
            pmax_we = 4'(1 << p);
            @(negedge clk);
         end
         pmax_we = '0;
         for (int p = 0; p < NPORT; p++) begin
            code[p] = ($urandom_range(0, 3) == 0) ? (p[0] ? 'h1FFF : 'h2000) : $urandom_range(0, 16383);
            i_equip.set_input(p, code[p][13:0]);
            i_equip.set_gauge(p, 13'($urandom), $urandom_range(0, 3) == 0, $urandom_range(0, 3) == 0);
            fmt_pressure[p] = 1'($urandom);
            dac_src[p] = 2'($urandom);
            dac_gauge[p] = 2'($urandom);
            manual_code[p] = 12'($urandom);
            remote_code[p] = 12'($urandom);
         end
         for (int c = 0; c < NCHAN; c++) begin
            chan_port[c] = 2'($urandom);
            chan_above[c] = 1'($urandom);
            chan_level[c] = 14'(code[chan_port[c]] + $urandom_range(0, 2) - 1);
         end
         log_enable = (r != 3);
         wait_tick();
         for (int p = 0; p < NPORT; p++) begin
            ov = !e_out[p] && (code[p] == 'h1FFF || code[p] == 'h2000);
            e_ovl[p] = ov;
            pv = !e_out[p] && fmt_pressure[p] && e_pmax[p] != 0 && !ov;
            if (!e_out[p]) check("reading", reading[p], code[p]);
            check("overload", overload[p], ov);
            check("pressure_valid", pressure_valid[p], pv);
            pr = (sx(code[p], 14) < 0) ? 0 : (longint'(code[p]) * e_pmax[p] * 2457) >> 24;
            if (pv) check("pressure", pressure[p], (pr > 'hFFFF) ? 'hFFFF : pr);
            g = dac_gauge[p];
            // the unused source code keeps the last level
            if (e_out[p] && dac_src[p] != 2'b10) begin
               e_dac[p] = (dac_src[p] == 0) ? manual_code[p] : (dac_src[p] == 1) ? remote_code[p] :
                  gauge_dac(g, sx(gauge_logp[g], 13), gauge_off[g], gauge_fault[g]);
            end
            check("dac_code", dac_code[p], e_dac[p]);
            if (log_enable && !e_out[p]) begin
               qa.push_back(e_ptr);
               qd.push_back((p << 15) | (ov << 14) | code[p]);
               e_ptr = (e_ptr + 1) % 256;
            end
         end
         for (int c = 0; c < NCHAN; c++) begin
            cp = chan_port[c];
            ov = !e_out[cp] && !e_ovl[cp] && (chan_above[c] ? sx(code[cp], 14) > sx(chan_level[c], 14) :
               sx(code[cp], 14) < sx(chan_level[c], 14));
            check("chan_active", chan_active[c], ov);
         end
         repeat (6) @(negedge clk);
         check("log_wr_ptr", log_wr_ptr, e_ptr);
         while (qa.size() > 0) begin
            log_rd_addr = 8'(qa.pop_front());
            @(negedge clk);
            check("log entry", log_rd_data, qd.pop_front());
         end
      end
      end_of_test();
   end

endmodule
